//--- logic/fuse_cfg_pkg.sv
package fuse_cfg_pkg;

  // Number of fuse bytes and their selector codes on the programmer port.
  localparam int FUSE_BYTES = 3;
  localparam logic [1:0] SEL_LOW = 2'h0;
  localparam logic [1:0] SEL_HIGH = 2'h1;
  localparam logic [1:0] SEL_EXT = 2'h2;

  // Identification row addresses.
  localparam logic [1:0] ID_ADDR_0 = 2'h0;
  localparam logic [1:0] ID_ADDR_1 = 2'h1;
  localparam logic [1:0] ID_ADDR_2 = 2'h2;

  // Factory defaults; a 0 bit is programmed, a 1 bit unprogrammed.
  localparam logic [7:0] EXT_RESET = 8'hFD;
  localparam logic [7:0] HIGH_RESET = 8'h99;
  localparam logic [7:0] LOW_RESET = 8'hE1;

  // Extended byte fields.
  localparam int EXT_LEGACY_BIT = 1;
  localparam int EXT_WDOG_BIT = 0;

  // High byte fields.
  localparam int HIGH_DEBUG_BIT = 7;
  localparam int HIGH_SCAN_BIT = 6;
  localparam int HIGH_SERIAL_BIT = 5;
  localparam int HIGH_OSC_BIT = 4;
  localparam int HIGH_EEPROM_PRESERVE_BIT = 3;
  localparam int HIGH_BOOT_HI_BIT = 2;
  localparam int HIGH_BOOT_LO_BIT = 1;
  localparam int HIGH_RSTVEC_BIT = 0;

  // Low byte fields.
  localparam int LOW_BOD_LEVEL_BIT = 7;
  localparam int LOW_BOD_EN_BIT = 6;
  localparam int LOW_SUT_HI_BIT = 5;
  localparam int LOW_SUT_LO_BIT = 4;
  localparam int LOW_CKSEL_MSB = 3;

  // Page geometry of flash and EEPROM.
  localparam int FLASH_WORD_MSB = 6;
  localparam int FLASH_PAGE_LSB = 7;
  localparam int FLASH_PAGE_MSB = 15;
  localparam int EE_BYTE_MSB = 2;
  localparam int EE_PAGE_LSB = 3;
  localparam int EE_PAGE_MSB = 11;

  // Decoded configuration, in active-high form for consumers, except brown-out level and the multi-bit fields, which are raw.
  typedef struct packed {
    logic legacy_compat_select;
    logic watchdog_force_on;
    logic onchip_debug_enable;
    logic scan_port_enable;
    logic serial_prog_enable;
    logic oscillator_option;
    logic eeprom_preserve;
    logic [1:0] boot_size;
    logic reset_vector_select;
    logic brownout_level;
    logic brownout_enable;
    logic [1:0] startup_time;
    logic [3:0] clock_source_sel;
  } cfg_t;

  // A programmer write request.
  typedef struct packed {
    logic valid;
    logic serial_path;
    logic [1:0] sel;
    logic [7:0] data;
  } fuse_wr_t;

endpackage

//--- logic/fuse_byte_cell.sv
`timescale 1ns/1ps
`default_nettype none

// One non-volatile fuse byte with its write protection.
module fuse_byte_cell #(
  parameter logic [7:0] RESET_VALUE = 8'hFF,
  parameter logic [7:0] SERIAL_LOCK_MASK = 8'h00
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Write request.
  input wire logic wr_en,
  input wire logic serial_path,
  input wire logic locked,
  input wire logic [7:0] wr_data,
  // Stored value.
  output logic [7:0] value
);

  // Stored byte; reset models an unprogrammed part at factory defaults.
  logic [7:0] cell_q;

  ////////////////////////////////////////////////////////////////////////
  // Writes are dropped while locked, and masked bits keep their value on the serial path.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cell_q <= RESET_VALUE;
    end else if (wr_en && !locked) begin
      if (serial_path) begin
        cell_q <= (wr_data & ~SERIAL_LOCK_MASK) | (cell_q & SERIAL_LOCK_MASK);
      end else begin
        cell_q <= wr_data;
      end
    end
  end

  assign value = cell_q;

endmodule

`default_nettype wire

//--- logic/fuse_signature_config_store.sv
`timescale 1ns/1ps
`default_nettype none

module fuse_signature_config_store #(
  parameter logic [7:0] ID_CODE_0 = 8'hA5, // Arbitrary identification value.
  parameter logic [7:0] ID_CODE_1 = 8'h5A, // Arbitrary identification value.
  parameter logic [7:0] ID_CODE_2 = 8'h3C, // Arbitrary identification value.
  parameter logic [7:0] CAL_1MHZ = 8'h80,
  parameter logic [7:0] CAL_2MHZ = 8'h80,
  parameter logic [7:0] CAL_4MHZ = 8'h80,
  parameter logic [7:0] CAL_8MHZ = 8'h80
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Mode and lock state from the programming front end.
  input wire logic prog_mode,
  input wire logic memory_lock_first,
  input wire logic chip_erase,
  // Fuse write request.
  input wire fuse_cfg_pkg::fuse_wr_t fuse_wr,
  // Fuse read-back request.
  input wire logic fuse_rd,
  input wire logic [1:0] fuse_rd_sel,
  output logic [7:0] fuse_rd_data,
  // Identification and calibration read request.
  input wire logic id_rd,
  input wire logic id_rd_high,
  input wire logic [1:0] id_rd_addr,
  output logic [7:0] id_rd_data,
  // Oscillator calibration register, software loadable.
  input wire logic cal_wr,
  input wire logic [7:0] cal_wr_data,
  output logic [7:0] osc_calibration_reg,
  // Address geometry.
  input wire logic [15:0] prog_counter,
  input wire logic [11:0] eeprom_addr,
  output logic [6:0] flash_word_in_page,
  output logic [8:0] flash_page_index,
  output logic [2:0] eeprom_byte_in_page,
  output logic [8:0] eeprom_page_index,
  // Latched configuration for the rest of the chip.
  output fuse_cfg_pkg::cfg_t cfg,
  output logic eeprom_preserve_live
);

  ////////////////////////////////////////////////////////////////////////
  // Reset synchroniser: asserts at once, releases after two edges.
  logic rst_meta_q;
  logic rst_sync_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fuse array: three cells with their factory defaults.
  logic [7:0] ext_val;
  logic [7:0] high_val;
  logic [7:0] low_val;
  logic wr_ext;
  logic wr_high;
  logic wr_low;

  // Chip erase has no path into the cells; only fuse writes and reset change them.
  // The chip_erase strobe is accepted and deliberately left unused here,
  // so no erase sequence can ever disturb a stored fuse byte.
  assign wr_ext = fuse_wr.valid && fuse_wr.sel == fuse_cfg_pkg::SEL_EXT;
  assign wr_high = fuse_wr.valid && fuse_wr.sel == fuse_cfg_pkg::SEL_HIGH;
  assign wr_low = fuse_wr.valid && fuse_wr.sel == fuse_cfg_pkg::SEL_LOW;

  // Extended byte: unused bits stay 1, legacy mode programmed by default.
  fuse_byte_cell #(
    .RESET_VALUE(fuse_cfg_pkg::EXT_RESET),
    .SERIAL_LOCK_MASK(8'h00)
  ) u_ext (
    .clk(clk),
    .rst_n(rst_sync_q),
    .wr_en(wr_ext),
    .serial_path(fuse_wr.serial_path),
    .locked(memory_lock_first),
    .wr_data(fuse_wr.data | 8'hFC),
    .value(ext_val)
  );

  // High byte: serial-enable bit protected on the serial path.
  fuse_byte_cell #(
    .RESET_VALUE(fuse_cfg_pkg::HIGH_RESET),
    .SERIAL_LOCK_MASK(8'h20)
  ) u_high (
    .clk(clk),
    .rst_n(rst_sync_q),
    .wr_en(wr_high),
    .serial_path(fuse_wr.serial_path),
    .locked(memory_lock_first),
    .wr_data(fuse_wr.data),
    .value(high_val)
  );

  // Low byte: brown-out, start-up and clock source.
  fuse_byte_cell #(
    .RESET_VALUE(fuse_cfg_pkg::LOW_RESET),
    .SERIAL_LOCK_MASK(8'h00)
  ) u_low (
    .clk(clk),
    .rst_n(rst_sync_q),
    .wr_en(wr_low),
    .serial_path(fuse_wr.serial_path),
    .locked(memory_lock_first),
    .wr_data(fuse_wr.data),
    .value(low_val)
  );

  ////////////////////////////////////////////////////////////////////////
  // Shadow copy, refreshed at power-up and on programming entry.
  typedef enum logic [2:0] {
    ST_POWERUP = 3'h1,
    ST_NORMAL = 3'h2,
    ST_PROG = 3'h4
  } latch_state_t;

  latch_state_t state_q;
  logic [7:0] ext_sh_q;
  logic [7:0] high_sh_q;
  logic [7:0] low_sh_q;
  logic do_latch;

  // Latch in the first cycle after reset and on each rising prog_mode.
  // Leaving programming mode does not relatch; new values wait for the next entry or power-up.
  assign do_latch = (state_q == ST_POWERUP) || (state_q == ST_NORMAL && prog_mode);

  // Mode tracker.
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q <= ST_POWERUP;
    end else begin
      case (state_q)
        ST_POWERUP: begin
          state_q <= prog_mode ? ST_PROG : ST_NORMAL;
        end
        ST_NORMAL: begin
          if (prog_mode) begin
            state_q <= ST_PROG;
          end
        end
        ST_PROG: begin
          if (!prog_mode) begin
            state_q <= ST_NORMAL;
          end
        end
        default: begin
          state_q <= ST_POWERUP;
        end
      endcase
    end
  end

  // Shadow bytes; held steady while programming so new values wait.
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      ext_sh_q <= fuse_cfg_pkg::EXT_RESET;
      high_sh_q <= fuse_cfg_pkg::HIGH_RESET;
      low_sh_q <= fuse_cfg_pkg::LOW_RESET;
    end else if (do_latch) begin
      ext_sh_q <= ext_val;
      high_sh_q <= high_val;
      low_sh_q <= low_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Decoded configuration outputs; a 0 fuse means the feature is on, except brown-out level and the multi-bit fields, which pass raw.
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      cfg <= '0;
      eeprom_preserve_live <= 1'b0;
    end else begin
      cfg.legacy_compat_select <= ~ext_sh_q[fuse_cfg_pkg::EXT_LEGACY_BIT];
      cfg.watchdog_force_on <= ~ext_sh_q[fuse_cfg_pkg::EXT_WDOG_BIT];
      cfg.onchip_debug_enable <= ~high_sh_q[fuse_cfg_pkg::HIGH_DEBUG_BIT];
      cfg.scan_port_enable <= ~high_sh_q[fuse_cfg_pkg::HIGH_SCAN_BIT];
      cfg.serial_prog_enable <= ~high_sh_q[fuse_cfg_pkg::HIGH_SERIAL_BIT];
      cfg.oscillator_option <= ~high_sh_q[fuse_cfg_pkg::HIGH_OSC_BIT];
      cfg.eeprom_preserve <= ~high_sh_q[fuse_cfg_pkg::HIGH_EEPROM_PRESERVE_BIT];
      cfg.boot_size <= {high_sh_q[fuse_cfg_pkg::HIGH_BOOT_HI_BIT], high_sh_q[fuse_cfg_pkg::HIGH_BOOT_LO_BIT]};
      cfg.reset_vector_select <= ~high_sh_q[fuse_cfg_pkg::HIGH_RSTVEC_BIT];
      cfg.brownout_level <= low_sh_q[fuse_cfg_pkg::LOW_BOD_LEVEL_BIT];
      cfg.brownout_enable <= ~low_sh_q[fuse_cfg_pkg::LOW_BOD_EN_BIT];
      cfg.startup_time <= {low_sh_q[fuse_cfg_pkg::LOW_SUT_HI_BIT], low_sh_q[fuse_cfg_pkg::LOW_SUT_LO_BIT]};
      cfg.clock_source_sel <= low_sh_q[fuse_cfg_pkg::LOW_CKSEL_MSB:0];
      // The preserve fuse bypasses the shadow so chip erase sees it at once.
      eeprom_preserve_live <= ~high_val[fuse_cfg_pkg::HIGH_EEPROM_PRESERVE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fuse read-back shows the live array in raw polarity.
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      fuse_rd_data <= 8'hFF;
    end else if (fuse_rd) begin
      if (fuse_rd_sel == fuse_cfg_pkg::SEL_EXT) begin
        fuse_rd_data <= ext_val;
      end else if (fuse_rd_sel == fuse_cfg_pkg::SEL_HIGH) begin
        fuse_rd_data <= high_val;
      end else if (fuse_rd_sel == fuse_cfg_pkg::SEL_LOW) begin
        fuse_rd_data <= low_val;
      end else begin
        fuse_rd_data <= 8'hFF;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Identification row: low byte is the ID code, high byte calibration.
  logic [7:0] cal_rom [4];

  assign cal_rom[0] = CAL_1MHZ;
  assign cal_rom[1] = CAL_2MHZ;
  assign cal_rom[2] = CAL_4MHZ;
  assign cal_rom[3] = CAL_8MHZ;

  // Lock state is not consulted, so the code stays readable when locked.
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      id_rd_data <= 8'h00;
    end else if (id_rd) begin
      if (id_rd_high) begin
        id_rd_data <= cal_rom[id_rd_addr];
      end else if (id_rd_addr == fuse_cfg_pkg::ID_ADDR_0) begin
        id_rd_data <= ID_CODE_0;
      end else if (id_rd_addr == fuse_cfg_pkg::ID_ADDR_1) begin
        id_rd_data <= ID_CODE_1;
      end else if (id_rd_addr == fuse_cfg_pkg::ID_ADDR_2) begin
        id_rd_data <= ID_CODE_2;
      end else begin
        id_rd_data <= 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Oscillator calibration register: 0 at reset, 1MHz value in the first cycle after, software after that.
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      osc_calibration_reg <= 8'h00;
    end else if (state_q == ST_POWERUP) begin
      osc_calibration_reg <= cal_rom[0];
    end else if (cal_wr) begin
      osc_calibration_reg <= cal_wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Page geometry split of program counter and EEPROM address.
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      flash_word_in_page <= '0;
      flash_page_index <= '0;
      eeprom_byte_in_page <= '0;
      eeprom_page_index <= '0;
    end else begin
      flash_word_in_page <= prog_counter[fuse_cfg_pkg::FLASH_WORD_MSB:0];
      flash_page_index <= prog_counter[fuse_cfg_pkg::FLASH_PAGE_MSB:fuse_cfg_pkg::FLASH_PAGE_LSB];
      eeprom_byte_in_page <= eeprom_addr[fuse_cfg_pkg::EE_BYTE_MSB:0];
      eeprom_page_index <= eeprom_addr[fuse_cfg_pkg::EE_PAGE_MSB:fuse_cfg_pkg::EE_PAGE_LSB];
    end
  end

endmodule

`default_nettype wire

//--- verif/fuse_store_sva.sv
`timescale 1ns/1ps
`default_nettype none

// Watches the store's ports for the timing and values that it promises.
module fuse_store_sva #(
  parameter logic [7:0] ID_CODE_0 = 8'hA5, // Arbitrary identification value.
  parameter logic [7:0] CAL_1MHZ = 8'h80
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Requests.
  input wire logic prog_mode,
  input wire logic memory_lock_first,
  input wire fuse_cfg_pkg::fuse_wr_t fuse_wr,
  input wire logic fuse_rd,
  input wire logic [1:0] fuse_rd_sel,
  input wire logic id_rd,
  input wire logic id_rd_high,
  input wire logic [1:0] id_rd_addr,
  input wire logic cal_wr,
  input wire logic [7:0] cal_wr_data,
  input wire logic [15:0] prog_counter,
  input wire logic [11:0] eeprom_addr,
  // Answers.
  input wire logic [7:0] fuse_rd_data,
  input wire logic [7:0] id_rd_data,
  input wire logic [7:0] osc_calibration_reg,
  input wire logic [6:0] flash_word_in_page,
  input wire logic [8:0] flash_page_index,
  input wire logic [2:0] eeprom_byte_in_page,
  input wire logic [8:0] eeprom_page_index,
  input wire fuse_cfg_pkg::cfg_t cfg,
  input wire logic eeprom_preserve_live
);
  // Copy of the store's reset release: bit 1 rises on the same edge as its internal reset.
  logic [1:0] up_q;

  // Registered outputs only follow their inputs once the internal reset has let go.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      up_q <= 2'h0;
    end else begin
      up_q <= {up_q[0], 1'h1};
    end
  end

  // All checks run on the core clock and rest while reset is low.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////
  a_lock_blocks_write: assert property (
    fuse_wr.valid && memory_lock_first |-> ##2 eeprom_preserve_live == $past(eeprom_preserve_live, 2))
    else $error("locked write changed the array");
  a_preserve_live: assert property (
    fuse_wr.valid && !memory_lock_first && fuse_wr.sel == fuse_cfg_pkg::SEL_HIGH
    |-> ##2 eeprom_preserve_live == !$past(fuse_wr.data[fuse_cfg_pkg::HIGH_EEPROM_PRESERVE_BIT], 2))
    else $error("preserve fuse did not act at once");
  a_shadow_held: assert property (
    prog_mode [*5] |-> $stable(cfg))
    else $error("configuration moved inside programming mode");
  a_osc_reset_load: assert property (
    $rose(rst_n) |-> ##[1:8] osc_calibration_reg == CAL_1MHZ)
    else $error("calibration not loaded at reset");
  a_osc_soft_load: assert property (
    cal_wr |=> osc_calibration_reg == $past(cal_wr_data))
    else $error("calibration write lost");
  a_flash_geometry: assert property (
    up_q[1] |=> flash_word_in_page == $past(prog_counter[6:0]) && flash_page_index == $past(prog_counter[15:7]))
    else $error("flash page split wrong");
  a_eeprom_geometry: assert property (
    up_q[1] |=> eeprom_byte_in_page == $past(eeprom_addr[2:0]) && eeprom_page_index == $past(eeprom_addr[11:3]))
    else $error("eeprom page split wrong");
  a_id_first_byte: assert property (
    id_rd && !id_rd_high && id_rd_addr == fuse_cfg_pkg::ID_ADDR_0 |=> id_rd_data == ID_CODE_0)
    else $error("identification byte wrong");
  a_ext_unused_ones: assert property (
    fuse_rd && fuse_rd_sel == fuse_cfg_pkg::SEL_EXT |=> fuse_rd_data[7:2] == 6'h3F)
    else $error("unused extended bits not one");
endmodule

bind fuse_signature_config_store fuse_store_sva #(.ID_CODE_0(ID_CODE_0), .CAL_1MHZ(CAL_1MHZ)) chk (
  .clk, .rst_n, .prog_mode, .memory_lock_first, .fuse_wr, .fuse_rd, .fuse_rd_sel, .id_rd, .id_rd_high,
  .id_rd_addr, .cal_wr, .cal_wr_data, .prog_counter, .eeprom_addr, .fuse_rd_data, .id_rd_data,
  .osc_calibration_reg, .flash_word_in_page, .flash_page_index, .eeprom_byte_in_page, .eeprom_page_index,
  .cfg, .eeprom_preserve_live);
`default_nettype wire

//--- verif/prog_model.sv
`timescale 1ns/1ps
`default_nettype none

// Programmer on the far side: strobes held for the minimum pulse width, lines scrambled once released.
module prog_model (
  // Clock.
  input wire logic clk,
  // Requests toward the store.
  output fuse_cfg_pkg::fuse_wr_t fuse_wr,
  output logic fuse_rd,
  output logic [1:0] fuse_rd_sel,
  output logic id_rd,
  output logic id_rd_high,
  output logic [1:0] id_rd_addr,
  // Answers from the store.
  input wire logic [7:0] fuse_rd_data,
  input wire logic [7:0] id_rd_data
);
  // Minimum control pulse of 250 ns, counted in 10 ns clock periods.
  localparam int PULSE_CYCLES = 25;
  // Everything idle at time zero.
  initial begin
    fuse_wr = '0;
    {fuse_rd, fuse_rd_sel, id_rd, id_rd_high, id_rd_addr} = '0;
  end
  // Write one fuse byte; data stands with the strobe, then is inverted.
  task automatic wr(input logic ser, input logic [1:0] sel, input logic [7:0] d);
    @(negedge clk);
    fuse_wr <= '{1'b1, ser, sel, d};
    repeat (PULSE_CYCLES) @(negedge clk);
    fuse_wr <= '{1'b0, ~ser, ~sel, ~d};
    repeat (3) @(negedge clk);
  endtask
  // Read a fuse byte or an identification byte into q.
  task automatic rd(input logic id, input logic hi, input logic [1:0] a, output logic [7:0] q);
    @(negedge clk);
    {fuse_rd, id_rd, id_rd_high, fuse_rd_sel, id_rd_addr} <= {!id, id, hi, a, a};
    repeat (PULSE_CYCLES) @(negedge clk);
    // The answer is taken while the strobe still stands, then the lines are released.
    q = id ? id_rd_data : fuse_rd_data;
    {fuse_rd, id_rd, id_rd_high, fuse_rd_sel, id_rd_addr} <= {2'b00, !hi, ~a, ~a};
  endtask
endmodule
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

// Walks the store through reset, reads, writes, locking and mode changes.
module tb_top;
  logic clk = 1'b0; // Core clock.
  logic rst_n, prog_mode, memory_lock_first, chip_erase, cal_wr; // Bench-driven levels and strobes.
  logic [7:0] cal_wr_data; // Calibration load value.
  logic [15:0] prog_counter; // Program counter fed to the geometry.
  logic [11:0] eeprom_addr; // EEPROM address fed to the geometry.
  fuse_cfg_pkg::fuse_wr_t fuse_wr; // Write request from the programmer.
  logic fuse_rd, id_rd, id_rd_high; // Read strobes from the programmer.
  logic [1:0] fuse_rd_sel, id_rd_addr; // Read selectors.
  logic [7:0] fuse_rd_data, id_rd_data, osc_calibration_reg, q; // Read answers.
  logic [6:0] flash_word_in_page; // Geometry outputs.
  logic [8:0] flash_page_index, eeprom_page_index;
  logic [2:0] eeprom_byte_in_page;
  fuse_cfg_pkg::cfg_t cfg; // Latched configuration.
  logic eeprom_preserve_live; // Live preserve flag.
  int err_total = 0;
  int comparisons = 0;
  logic [7:0] fexp [4] = '{8'hE1, 8'h99, 8'hFD, 8'hFF}; // Low, high, extended, then the unused selector.
  logic [7:0] idexp [4] = '{8'hC6, 8'h6C, 8'h9D, 8'h00}; // Identification row, low half; codes are arbitrary.
  logic [7:0] calexp [4] = '{8'h11, 8'h22, 8'h44, 8'h88}; // Calibration for 1, 2, 4, 8 MHz.

  // 100 MHz clock.
  always #5 clk = ~clk;

  fuse_signature_config_store #(
    .ID_CODE_0(8'hC6), .ID_CODE_1(8'h6C), .ID_CODE_2(8'h9D), // Arbitrary identification values.
    .CAL_1MHZ(8'h11), .CAL_2MHZ(8'h22), .CAL_4MHZ(8'h44), .CAL_8MHZ(8'h88)) dut (
    .clk, .rst_n, .prog_mode, .memory_lock_first, .chip_erase, .fuse_wr, .fuse_rd, .fuse_rd_sel,
    .fuse_rd_data, .id_rd, .id_rd_high, .id_rd_addr, .id_rd_data, .cal_wr, .cal_wr_data,
    .osc_calibration_reg, .prog_counter, .eeprom_addr, .flash_word_in_page, .flash_page_index,
    .eeprom_byte_in_page, .eeprom_page_index, .cfg, .eeprom_preserve_live);
  prog_model pm (.clk, .fuse_wr, .fuse_rd, .fuse_rd_sel, .id_rd, .id_rd_high, .id_rd_addr,
    .fuse_rd_data, .id_rd_data);

  ////////////////////////////////////////////////////////////////
  // Compare one value and report a mismatch at once.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Active-high view of three raw fuse bytes, with brown-out level and the multi-bit fields kept raw.
  function automatic fuse_cfg_pkg::cfg_t dec(input logic [7:0] e, input logic [7:0] h, input logic [7:0] l);
    dec = {~e[1:0], ~h[7:3], h[2:1], ~h[0], l[7], ~l[6], l[5:0]};
  endfunction
  // Print the counts and the verdict, then stop.
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    {rst_n, prog_mode, memory_lock_first, chip_erase, cal_wr} = '0;
    {cal_wr_data, prog_counter, eeprom_addr} = '0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    chk("osc", 8'h11, osc_calibration_reg);
    chk("cfg", dec(8'hFD, 8'h99, 8'hE1), cfg);
    for (int i = 0; i < 4; i++) begin
      pm.rd(1'b0, 1'b0, 2'(i), q);
      chk("fuse", fexp[i], q);
      pm.rd(1'b1, 1'b0, 2'(i), q);
      chk("id", idexp[i], q);
      pm.rd(1'b1, 1'b1, 2'(i), q);
      chk("cal", calexp[i], q);
    end
    prog_counter = 16'hABCD;
    eeprom_addr = 12'hA5B;
    repeat (2) @(negedge clk);
    chk("fpage", {prog_counter[15:7], prog_counter[6:0]}, {flash_page_index, flash_word_in_page});
    chk("epage", {eeprom_addr[11:3], eeprom_addr[2:0]}, {eeprom_page_index, eeprom_byte_in_page});
    {cal_wr, cal_wr_data} = {1'b1, 8'h5C};
    @(negedge clk);
    cal_wr = 1'b0;
    @(negedge clk);
    chk("osc", 8'h5C, osc_calibration_reg);
    // Enter programming mode, then alter the fuses.
    prog_mode = 1'b1;
    repeat (3) @(negedge clk);
    pm.wr(1'b0, fuse_cfg_pkg::SEL_HIGH, 8'h91);
    chk("live", 1'b1, eeprom_preserve_live);
    pm.wr(1'b1, fuse_cfg_pkg::SEL_HIGH, 8'hB0);
    pm.rd(1'b0, 1'b0, fuse_cfg_pkg::SEL_HIGH, q);
    chk("serial", 8'h90, q);
    pm.wr(1'b0, fuse_cfg_pkg::SEL_EXT, 8'h00);
    pm.rd(1'b0, 1'b0, fuse_cfg_pkg::SEL_EXT, q);
    chk("ext", 8'hFC, q);
    chip_erase = 1'b1;
    @(negedge clk);
    chip_erase = 1'b0;
    pm.rd(1'b0, 1'b0, fuse_cfg_pkg::SEL_HIGH, q);
    chk("erase", 8'h90, q);
    memory_lock_first = 1'b1;
    pm.wr(1'b0, fuse_cfg_pkg::SEL_LOW, 8'h00);
    pm.rd(1'b0, 1'b0, fuse_cfg_pkg::SEL_LOW, q);
    chk("locked", 8'hE1, q);
    // A locked write to the high byte would clear the preserve fuse if it landed.
    pm.wr(1'b0, fuse_cfg_pkg::SEL_HIGH, 8'h99);
    pm.rd(1'b0, 1'b0, fuse_cfg_pkg::SEL_HIGH, q);
    chk("locked high", 8'h90, q);
    chk("live locked", 1'b1, eeprom_preserve_live);
    pm.rd(1'b1, 1'b0, fuse_cfg_pkg::ID_ADDR_2, q);
    chk("id locked", idexp[2], q);
    memory_lock_first = 1'b0;
    chk("cfg held", dec(8'hFD, 8'h99, 8'hE1), cfg);
    // Leave and re-enter: the new bytes are latched on entry.
    prog_mode = 1'b0;
    repeat (3) @(negedge clk);
    prog_mode = 1'b1;
    repeat (3) @(negedge clk);
    chk("cfg entry", dec(8'hFC, 8'h90, 8'hE1), cfg);
    prog_mode = 1'b0;
    // A second power-up reset in mid-run.
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    chk("osc again", 8'h11, osc_calibration_reg);
    chk("cfg again", dec(8'hFD, 8'h99, 8'hE1), cfg);
    close_out();
  end
endmodule
`default_nettype wire
